// file: hdl/tcu_top.sv
// three timer/counter unit with its special function registers
`timescale 1ns/10ps
`include "tcu_params.svh"

// What this block does
// - timer zero or one in timer operation steps once every 12 clocks
// - in counter operation a timer steps on each falling edge of its pin
// - edge detection takes two clocks; pin levels must hold one clock
// - mode zero counts 13 bits; low byte upper three bits untouched
// - mode one counts the full 16 bits over both bytes
// - mode two is an 8-bit counter that reloads on overflow
// - timer zero mode three splits in two 8-bit parts; timer one in mode three freezes
// - timer one keeps running while timer zero is split, without flag
// - third timer picks timer, event or gated operation from two bits
// - third timer steps every 12 clocks, or 24 with prescale select set
// - third timer event input sampled each clock, steps after a fall
// - gated third timer steps only while its input is high
// - reload mode zero loads the compare/reload value on overflow
// - reload mode one loads on each fall of half low-frequency clock
// - capture registers snapshot the third timer without disturbing it
// - control bit 7 flags timer one overflow, bit 5 timer zero
// - control bits 6 and 4 run timer one and zero
// - bits 3 and 1 are external flags; bits 2 and 0 pick edge or level
// - overflow and external flags clear on service routine entry
// - mode register holds select and mode fields per timer, a gate field for timer zero only
// - third timer input select: stop, clock, falling edges, gated
// - reload field: upper bit zero off, 10 mode zero, 11 mode one
module tcu_top (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// special function register port
	input  wire tcu_pkg::tcu_sfr_req_t sfr_req,
	output logic [7:0]                 sfr_rdata,
	input  wire tcu_pkg::tcu_ack_t     isr_ack,
	// pins
	input  wire logic                  timer_zero_count_pin,
	input  wire logic                  timer_one_count_pin,
	input  wire logic                  third_timer_ext_input,
	input  wire logic                  ext_irq_zero_pin,
	input  wire logic                  ext_irq_one_pin,
	input  wire logic                  low_frequency_clock,
	// status towards the processor core
	output logic [7:0]                 timer_control_flags,
	output logic                       timer_one_ovf_pulse,
	output logic                       third_timer_ovf_pulse
);
	import tcu_pkg::*;

	// ***********************************************
	// registers and wires
	// ***********************************************
	logic [7:0]  timer_mode_select_reg_q, third_timer_control_reg_q, ccen_q;
	logic [7:0]  tl0_q, th0_q, tl1_q, th1_q;
	logic [15:0] t2_q, t2_d;
	logic [15:0] cc_q [0:3];
	logic [`TCU_PRESC_W-1:0] presc_q;
	logic        half_q, third_timer_reload_trigger_q;
	logic        tick12, tick24, t2tick;
	logic        lvl_t0, lvl_t2, lvl_i0, lvl_i1;
	logic        fall_t0, fall_t1, fall_t2, fall_i0, fall_i1, lf_rise;
	tcu_mode_t   timer_zero_mode_field, timer_one_mode_field;
	tcu_t2src_t  t2src;
	logic        t0_split, run0, run1, t0_step, t1_step, th0_step;
	logic [16:0] t0_nx, t1_nx;
	logic [8:0]  th0_nx;
	logic        t2_step, t2_ovf, t2_reload, third_timer_reload_trigger_fall;
	logic        wr_tctl;
	logic        tf1_set, tf0_set, ie1_set, ie0_set;

	// one step of a classic timer: returns {overflow, high, low}
	function automatic logic [16:0] tcu_count(tcu_mode_t m,
		logic [7:0] hi, logic [7:0] lo);
		logic [13:0] s13;
		logic [8:0]  s8;
		s13 = {1'b0, hi, lo[4:0]} + 14'h1;
		s8  = {1'b0, lo} + 9'h1;
		unique case (m)
			TCU_MODE13: tcu_count = {s13[13], s13[12:5], lo[7:5],
				s13[4:0]};
			TCU_MODE16: tcu_count = {1'b0, hi, lo} + 17'h1;
			TCU_MODE8AR: tcu_count = {s8[8], hi,
				s8[8] ? hi : s8[7:0]};
			TCU_MODESPLIT: tcu_count = {s8[8], hi, s8[7:0]};
		endcase
	endfunction : tcu_count

	// ***********************************************
	// pin sampling
	// ***********************************************
	tcu_edge u_t0 (.core_clk(core_clk), .rst(rst),
		.pin(timer_zero_count_pin), .level(lvl_t0), .rise(),
		.fall(fall_t0));
	tcu_edge u_t1 (.core_clk(core_clk), .rst(rst),
		.pin(timer_one_count_pin), .level(), .rise(), .fall(fall_t1));
	tcu_edge u_t2 (.core_clk(core_clk), .rst(rst),
		.pin(third_timer_ext_input), .level(lvl_t2), .rise(),
		.fall(fall_t2));
	tcu_edge u_i0 (.core_clk(core_clk), .rst(rst),
		.pin(ext_irq_zero_pin), .level(lvl_i0), .rise(),
		.fall(fall_i0));
	tcu_edge u_i1 (.core_clk(core_clk), .rst(rst),
		.pin(ext_irq_one_pin), .level(lvl_i1), .rise(),
		.fall(fall_i1));
	tcu_edge u_lf (.core_clk(core_clk), .rst(rst),
		.pin(low_frequency_clock), .level(), .rise(lf_rise),
		.fall());

	// ***********************************************
	// prescalers
	// ***********************************************
	assign tick12 = (presc_q == `TCU_PRESC_W'(`TCU_PRESC_CYC - 1));
	assign tick24 = tick12 & half_q;

	// divide by twelve, then by two for the slow third-timer rate
	always_ff @(posedge core_clk) begin
		if (rst) begin
			presc_q <= '0;
			half_q  <= 1'b0;
		end else if (tick12) begin
			presc_q <= '0;
			half_q  <= ~half_q;
		end else begin
			presc_q <= presc_q + `TCU_PRESC_W'(1);
		end
	end

	// reload trigger runs at half the low-frequency clock
	always_ff @(posedge core_clk) begin
		if (rst)
			third_timer_reload_trigger_q <= 1'b0;
		else if (lf_rise)
			third_timer_reload_trigger_q <= ~third_timer_reload_trigger_q;
	end
	assign third_timer_reload_trigger_fall = lf_rise & third_timer_reload_trigger_q;

	// ***********************************************
	// timer zero and timer one
	// ***********************************************
	assign timer_zero_mode_field    = tcu_mode_t'(timer_mode_select_reg_q[1:0]);
	assign timer_one_mode_field    = tcu_mode_t'(timer_mode_select_reg_q[5:4]);
	assign t0_split = (timer_zero_mode_field == TCU_MODESPLIT);
	assign run0     = timer_control_flags[`TCU_TCTL_TR0] &
		(~timer_mode_select_reg_q[`TCU_TIMER_MODE_SELECT_REG_TIMER_ZERO_GATE_ENABLE] | lvl_i0);
	// while timer zero is split its high byte owns the timer one run bit,
	// so timer one then runs free and is stopped only by its mode three
	assign run1     = timer_control_flags[`TCU_TCTL_TR1] | t0_split;
	assign t0_step  = run0 & (timer_mode_select_reg_q[`TCU_TIMER_MODE_SELECT_REG_CT0] ? fall_t0 : tick12);
	assign t1_step  = run1 & (timer_one_mode_field != TCU_MODESPLIT) &
		(timer_mode_select_reg_q[`TCU_TIMER_MODE_SELECT_REG_CT1] ? fall_t1 : tick12);
	assign th0_step = t0_split & timer_control_flags[`TCU_TCTL_TR1] &
		tick12;

	// next counts; a bus write in the same cycle wins over counting
	always_comb begin
		t0_nx  = {1'b0, th0_q, tl0_q};
		t1_nx  = {1'b0, th1_q, tl1_q};
		th0_nx = {1'b0, th0_q};
		if (t0_step)
			t0_nx = tcu_count(timer_zero_mode_field, th0_q, tl0_q);
		if (t1_step)
			t1_nx = tcu_count(timer_one_mode_field, th1_q, tl1_q);
		if (th0_step)
			th0_nx = {1'b0, th0_q} + 9'h1;
	end

	// timer byte registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tl0_q <= `TCU_RST_BYTE;
			th0_q <= `TCU_RST_BYTE;
			tl1_q <= `TCU_RST_BYTE;
			th1_q <= `TCU_RST_BYTE;
		end else begin
			tl0_q <= (sfr_req.wr && sfr_req.addr == `TCU_ADDR_TL0) ?
				sfr_req.wdata : t0_nx[7:0];
			th0_q <= (sfr_req.wr && sfr_req.addr == `TCU_ADDR_TH0) ?
				sfr_req.wdata : (t0_split ? th0_nx[7:0] : t0_nx[15:8]);
			tl1_q <= (sfr_req.wr && sfr_req.addr == `TCU_ADDR_TL1) ?
				sfr_req.wdata : t1_nx[7:0];
			th1_q <= (sfr_req.wr && sfr_req.addr == `TCU_ADDR_TH1) ?
				sfr_req.wdata : t1_nx[15:8];
		end
	end

	// ***********************************************
	// control flags
	// ***********************************************
	assign wr_tctl = sfr_req.wr && (sfr_req.addr == `TCU_ADDR_TCTL);
	assign tf0_set = t0_nx[16];
	// a split timer zero borrows the timer one flag for its high byte
	assign tf1_set = t0_split ? th0_nx[8] : t1_nx[16];
	assign ie0_set = timer_control_flags[`TCU_TCTL_IT0] ? fall_i0 : ~lvl_i0;
	assign ie1_set = timer_control_flags[`TCU_TCTL_IT1] ? fall_i1 : ~lvl_i1;

	// hardware set wins over a write or a service-entry clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			timer_control_flags <= `TCU_RST_BYTE;
		end else begin
			if (wr_tctl)
				timer_control_flags <= sfr_req.wdata;
			else begin
				if (isr_ack.tf1)
					timer_control_flags[`TCU_TCTL_TF1] <= 1'b0;
				if (isr_ack.tf0)
					timer_control_flags[`TCU_TCTL_TF0] <= 1'b0;
				if (isr_ack.ie1)
					timer_control_flags[`TCU_TCTL_IE1] <= 1'b0;
				if (isr_ack.ie0)
					timer_control_flags[`TCU_TCTL_IE0] <= 1'b0;
			end
			if (tf1_set)
				timer_control_flags[`TCU_TCTL_TF1] <= 1'b1;
			if (tf0_set)
				timer_control_flags[`TCU_TCTL_TF0] <= 1'b1;
			if (ie1_set)
				timer_control_flags[`TCU_TCTL_IE1] <= 1'b1;
			if (ie0_set)
				timer_control_flags[`TCU_TCTL_IE0] <= 1'b1;
		end
	end

	// ***********************************************
	// third timer
	// ***********************************************
	assign t2src   = tcu_t2src_t'(third_timer_control_reg_q[1:0]);
	assign t2tick  = third_timer_control_reg_q[`TCU_T2_PS] ? tick24 : tick12;

	// operation select
	always_comb begin
		unique case (t2src)
			TCU_T2_STOP:  t2_step = 1'b0;
			TCU_T2_CLK:   t2_step = t2tick;
			TCU_T2_EVENT: t2_step = fall_t2;
			TCU_T2_GATED: t2_step = t2tick & lvl_t2;
		endcase
	end

	assign t2_ovf    = t2_step & (t2_q == 16'hffff);
	assign t2_reload = ((third_timer_control_reg_q[4:3] == `TCU_T2R_TIMER_ZERO_MODE_FIELD) & t2_ovf) |
		((third_timer_control_reg_q[4:3] == `TCU_T2R_TIMER_ONE_MODE_FIELD) & third_timer_reload_trigger_fall);

	// reload beats counting, a byte write beats both
	always_comb begin
		t2_d = t2_q;
		if (t2_reload)
			t2_d = cc_q[0];
		else if (t2_step)
			t2_d = t2_q + 16'h1;
		if (sfr_req.wr && sfr_req.addr == `TCU_ADDR_TL2)
			t2_d[7:0] = sfr_req.wdata;
		if (sfr_req.wr && sfr_req.addr == `TCU_ADDR_TH2)
			t2_d[15:8] = sfr_req.wdata;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			t2_q <= 16'h0000;
		else
			t2_q <= t2_d;
	end

	// ***********************************************
	// compare/reload and capture registers
	// ***********************************************
	// entry 0 is the compare/reload register, 1..3 the capture registers;
	// a low-byte write in capture mode snapshots the count instead
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++)
				cc_q[i] <= 16'h0000;
		end else if (sfr_req.wr) begin
			for (int i = 0; i < 4; i++) begin
				if (sfr_req.addr == (i == 0 ? `TCU_ADDR_CRCL :
					8'(`TCU_ADDR_CCL1 + 2 * (i - 1)))) begin
					if (ccen_q[2*i +: 2] == `TCU_COCA_CAPT)
						cc_q[i] <= t2_q;
					else
						cc_q[i][7:0] <= sfr_req.wdata;
				end
				if (sfr_req.addr == (i == 0 ? `TCU_ADDR_CRCH :
					8'(`TCU_ADDR_CCL1 + 2 * (i - 1) + 1)))
					cc_q[i][15:8] <= sfr_req.wdata;
			end
		end
	end

	// ***********************************************
	// configuration registers and read port
	// ***********************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			timer_mode_select_reg_q  <= `TCU_RST_BYTE;
			third_timer_control_reg_q <= `TCU_RST_BYTE;
			ccen_q  <= `TCU_RST_BYTE;
		end else if (sfr_req.wr) begin
			if (sfr_req.addr == `TCU_ADDR_TIMER_MODE_SELECT_REG)
				timer_mode_select_reg_q <= {1'b0, sfr_req.wdata[6:0]};
			if (sfr_req.addr == `TCU_ADDR_T2CTL)
				third_timer_control_reg_q <= sfr_req.wdata;
			if (sfr_req.addr == `TCU_ADDR_CCEN)
				ccen_q <= sfr_req.wdata;
		end
	end

	// read data lands one cycle after the request; unmapped reads zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				`TCU_ADDR_TCTL:  sfr_rdata <= timer_control_flags;
				`TCU_ADDR_TIMER_MODE_SELECT_REG:  sfr_rdata <= timer_mode_select_reg_q;
				`TCU_ADDR_TL0:   sfr_rdata <= tl0_q;
				`TCU_ADDR_TH0:   sfr_rdata <= th0_q;
				`TCU_ADDR_TL1:   sfr_rdata <= tl1_q;
				`TCU_ADDR_TH1:   sfr_rdata <= th1_q;
				`TCU_ADDR_T2CTL: sfr_rdata <= third_timer_control_reg_q;
				`TCU_ADDR_TL2:   sfr_rdata <= t2_q[7:0];
				`TCU_ADDR_TH2:   sfr_rdata <= t2_q[15:8];
				`TCU_ADDR_CCEN:  sfr_rdata <= ccen_q;
				`TCU_ADDR_CRCL:  sfr_rdata <= cc_q[0][7:0];
				`TCU_ADDR_CRCH:  sfr_rdata <= cc_q[0][15:8];
				8'hc2:           sfr_rdata <= cc_q[1][7:0];
				8'hc3:           sfr_rdata <= cc_q[1][15:8];
				8'hc4:           sfr_rdata <= cc_q[2][7:0];
				8'hc5:           sfr_rdata <= cc_q[2][15:8];
				8'hc6:           sfr_rdata <= cc_q[3][7:0];
				8'hc7:           sfr_rdata <= cc_q[3][15:8];
				default:         sfr_rdata <= 8'h00;
			endcase
		end
	end

	// overflow strobes for the serial port and the core
	always_ff @(posedge core_clk) begin
		if (rst) begin
			timer_one_ovf_pulse   <= 1'b0;
			third_timer_ovf_pulse <= 1'b0;
		end else begin
			timer_one_ovf_pulse   <= t1_nx[16];
			third_timer_ovf_pulse <= t2_ovf;
		end
	end

	// ***********************************************
	// assertions
	// ***********************************************
	AST_TICK12: assert property (@(posedge core_clk) disable iff (rst)
		tick12 |=> !tick12 [*8] ##4 tick12)
		else $error("prescale tick not every 12 clocks");
	AST_TICK24: assert property (@(posedge core_clk) disable iff (rst)
		tick24 |-> ##24 tick24)
		else $error("slow tick not every 24 clocks");
	AST_T0_EDGE: assert property (@(posedge core_clk) disable iff (rst)
		(timer_zero_mode_field == TCU_MODE16 && timer_mode_select_reg_q[2] && run0 && fall_t0 &&
		!sfr_req.wr) |=> {th0_q, tl0_q} == $past(t0_nx[15:0]))
		else $error("counter did not follow pin fall");
	AST_M0_TOP: assert property (@(posedge core_clk) disable iff (rst)
		(timer_zero_mode_field == TCU_MODE13 && !sfr_req.wr) |=> $stable(tl0_q[7:5]))
		else $error("mode zero changed low byte top bits");
	AST_AR_LOAD: assert property (@(posedge core_clk) disable iff (rst)
		(timer_one_mode_field == TCU_MODE8AR && t1_step && tl1_q == 8'hff &&
		!sfr_req.wr) |=> tl1_q == th1_q && $stable(th1_q))
		else $error("auto reload wrong");
	AST_T1_FRZ: assert property (@(posedge core_clk) disable iff (rst)
		(timer_one_mode_field == TCU_MODESPLIT && !sfr_req.wr) |=>
		$stable(tl1_q) && $stable(th1_q))
		else $error("timer one moved in mode three");
	AST_T2_EVT: assert property (@(posedge core_clk) disable iff (rst)
		(t2src == TCU_T2_EVENT && fall_t2 && !t2_reload && !sfr_req.wr)
		|=> t2_q == $past(t2_q) + 16'h1)
		else $error("event count missed");
	AST_T2_GATE: assert property (@(posedge core_clk) disable iff (rst)
		(t2src == TCU_T2_GATED && !lvl_t2 && !t2_reload && !sfr_req.wr)
		|=> $stable(t2_q))
		else $error("gated timer ran while gate low");
	AST_T2_RLD: assert property (@(posedge core_clk) disable iff (rst)
		(t2_reload && !sfr_req.wr) |=> t2_q == $past(cc_q[0]))
		else $error("reload value wrong");
	AST_TF0: assert property (@(posedge core_clk) disable iff (rst)
		tf0_set |=> timer_control_flags[5])
		else $error("overflow flag not set");

endmodule : tcu_top

// file: hdl/tcu_params.svh
// register addresses, field positions, reset values and timing counts
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH

// ***********************************************
// register addresses
// ***********************************************
`define TCU_ADDR_TCTL   8'h88
`define TCU_ADDR_TIMER_MODE_SELECT_REG   8'h89
`define TCU_ADDR_TL0    8'h8a
`define TCU_ADDR_TL1    8'h8b
`define TCU_ADDR_TH0    8'h8c
`define TCU_ADDR_TH1    8'h8d
`define TCU_ADDR_CCEN   8'hc1
`define TCU_ADDR_CCL1   8'hc2
`define TCU_ADDR_T2CTL  8'hc8
`define TCU_ADDR_CRCL   8'hca
`define TCU_ADDR_CRCH   8'hcb
`define TCU_ADDR_TL2    8'hcc
`define TCU_ADDR_TH2    8'hcd

// ***********************************************
// field positions
// ***********************************************
`define TCU_TCTL_TF1    7
`define TCU_TCTL_TR1    6
`define TCU_TCTL_TF0    5
`define TCU_TCTL_TR0    4
`define TCU_TCTL_IE1    3
`define TCU_TCTL_IT1    2
`define TCU_TCTL_IE0    1
`define TCU_TCTL_IT0    0
`define TCU_TIMER_MODE_SELECT_REG_CT1    6
`define TCU_TIMER_MODE_SELECT_REG_TIMER_ZERO_GATE_ENABLE  3
`define TCU_TIMER_MODE_SELECT_REG_CT0    2
`define TCU_T2_PS       7
`define TCU_COCA_CAPT   2'b11
`define TCU_T2R_TIMER_ZERO_MODE_FIELD   2'b10
`define TCU_T2R_TIMER_ONE_MODE_FIELD   2'b11

// ***********************************************
// reset values and timing
// ***********************************************
`define TCU_RST_BYTE    8'h00
`define TCU_PRESC_CYC   12
`define TCU_PRESC_W     4

`endif

// file: hdl/tcu_pkg.sv
// types shared by the timer/counter unit
package tcu_pkg;

	// special function register access, one cycle per request
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} tcu_sfr_req_t;

	// service routine entry acknowledges, one-cycle pulses
	typedef struct packed {
		logic tf1;
		logic tf0;
		logic ie1;
		logic ie0;
	} tcu_ack_t;

	typedef enum logic [1:0] {
		TCU_MODE13,
		TCU_MODE16,
		TCU_MODE8AR,
		TCU_MODESPLIT
	} tcu_mode_t;

	typedef enum logic [1:0] {
		TCU_T2_STOP,
		TCU_T2_CLK,
		TCU_T2_EVENT,
		TCU_T2_GATED
	} tcu_t2src_t;

endpackage : tcu_pkg

// file: hdl/tcu_edge.sv
// input sampler with rise and fall detection
`timescale 1ns/10ps

module tcu_edge (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// pin side
	input  wire logic pin,
	// detected events
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic prev_q;

	// two samples are needed, so a pin toggles at half clock rate at most
	always_ff @(posedge core_clk) begin
		if (rst) begin
			level  <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			level  <= pin;
			prev_q <= level;
		end
	end

	assign fall = prev_q & ~level;
	assign rise = ~prev_q & level;

endmodule : tcu_edge

// file: tb/tcu_pin_model.sv
// pin model for count, gate, irq and slow clock inputs
`timescale 1ns/10ps

module tcu_pin_model (
	// clock
	input  wire logic core_clk,
	// pins towards the timer unit
	output logic      timer_zero_count_pin,
	output logic      timer_one_count_pin,
	output logic      third_timer_ext_input,
	output logic      ext_irq_zero_pin,
	output logic      ext_irq_one_pin,
	output logic      low_frequency_clock
);
	logic [4:0] pin_q;

	// pins idle high so no edge or level flag shows up unasked
	assign {ext_irq_one_pin, ext_irq_zero_pin, third_timer_ext_input,
		timer_one_count_pin, timer_zero_count_pin} = pin_q;

	// slow reference runs free, 32 core cycles a period
	initial begin
		pin_q = 5'h1f;
		low_frequency_clock = 1'b0;
		forever begin
			repeat (16) @(posedge core_clk);
			#1;
			low_frequency_clock = ~low_frequency_clock;
		end
	end

	// drive one pin to a fixed level
	task automatic set_pin(input int idx, input logic v);
		pin_q[idx] = v;
	endtask : set_pin

	// falling edges, each level held whole cycles after an edge
	task automatic pulse(input int idx, input int n, input int hold);
		for (int i = 0; i < n; i++) begin
			pin_q[idx] = 1'b0;
			repeat (hold) @(posedge core_clk);
			#1;
			pin_q[idx] = 1'b1;
			repeat (hold) @(posedge core_clk);
			#1;
		end
	endtask : pulse

endmodule : tcu_pin_model

// file: tb/tcu_top_tb.sv
// self-checking bench for the three timer/counter unit
`timescale 1ns/10ps
`include "tcu_params.svh"
`define TCU_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	failures++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module tcu_top_tb;
	import tcu_pkg::*;
	logic         core_clk;
	logic         rst;
	tcu_sfr_req_t req;
	tcu_ack_t     ack;
	logic [7:0]   rdata;
	logic         t1_ovf;
	logic         t2_ovf_p;
	int           t2_pulses;
	logic         t0p, t1p, t2p, i0p, i1p, lfclk;
	int           failures;
	int           checks_done;
	int           t1_pulses;
	int           n;
	int           n0;
	logic [7:0]   seed;
	logic [7:0]   h;
	logic [7:0]   l;
	logic [16:0]  st;
	logic         ovf;

	tcu_pin_model u_pins (
		.core_clk              (core_clk),
		.timer_zero_count_pin  (t0p),
		.timer_one_count_pin   (t1p),
		.third_timer_ext_input (t2p),
		.ext_irq_zero_pin      (i0p),
		.ext_irq_one_pin       (i1p),
		.low_frequency_clock   (lfclk)
	);

	tcu_top u_dut (
		.core_clk              (core_clk),
		.rst                   (rst),
		.sfr_req               (req),
		.sfr_rdata             (rdata),
		.isr_ack               (ack),
		.timer_zero_count_pin  (t0p),
		.timer_one_count_pin   (t1p),
		.third_timer_ext_input (t2p),
		.ext_irq_zero_pin      (i0p),
		.ext_irq_one_pin       (i1p),
		.low_frequency_clock   (lfclk),
		.timer_control_flags   (),
		.timer_one_ovf_pulse   (t1_ovf),
		.third_timer_ovf_pulse (t2_ovf_p)
	);

	// ************
	// clock, pulse counter, watchdog
	// ************
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// counts overflow pulses of timer one and of the third timer
	always @(posedge core_clk) begin
		if (t1_ovf === 1'b1) t1_pulses++;
		if (t2_ovf_p === 1'b1) t2_pulses++;
	end

	// whole run is some 1200 cycles; this cuts a hang well beyond
	initial begin
		#100000;
		failures++;
		wrap_up();
	end

	// ************
	// model and bus tasks
	// ************
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// one count step of timer zero: {overflow, high, low}
	function automatic logic [16:0] t0_step(input logic [1:0] m,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [13:0] s13;
		s13 = {1'b0, hi, lo[4:0]} + 14'h1;
		case (m)
			2'd0: return {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			2'd1: return {1'b0, hi, lo} + 17'h1;
			2'd2: return (lo == 8'hff) ? {1'b1, hi, hi} :
				{1'b0, hi, lo + 8'h1};
			default: return {lo == 8'hff, hi, lo + 8'h1};
		endcase
	endfunction : t0_step

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		req = '{addr: ad, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge core_clk);
		#1;
		req.wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		req = '{addr: ad, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge core_clk);
		#1;
		req.rd = 1'b0;
		d = rdata;
	endtask : rd

	task automatic chk_rd(input logic [7:0] ad, input logic [7:0] e);
		logic [7:0] d;
		rd(ad, d);
		`TCU_CHK(d, e)
	endtask : chk_rd

	// two reads exactly gap cycles apart must differ by k
	task automatic rate(input logic [7:0] ad, input int gap, input int k);
		logic [7:0] x;
		logic [7:0] y;
		rd(ad, x);
		repeat (gap - 2) @(posedge core_clk);
		rd(ad, y);
		`TCU_CHK(y, 8'(x + k))
	endtask : rate

	task automatic ackp(input tcu_ack_t v);
		@(posedge core_clk);
		#1;
		ack = v;
		@(posedge core_clk);
		#1;
		ack = '0;
	endtask : ackp

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// ************
	// tests
	// ************
	initial begin
		req = '0;
		ack = '0;
		rst = 1'b1;
		failures = 0;
		checks_done = 0;
		t1_pulses = 0;
		t2_pulses = 0;
		seed = 8'h11;
		repeat (2) @(posedge core_clk);
		#1;
		rst = 1'b0;
		chk_rd(`TCU_ADDR_TCTL, 8'h00);
		chk_rd(`TCU_ADDR_TIMER_MODE_SELECT_REG, 8'h00);
		wr(8'h80, 8'hff);
		chk_rd(8'h80, 8'h00);
		done("reset");
		// timer rate, then stop by clearing the run bit
		wr(`TCU_ADDR_TIMER_MODE_SELECT_REG, 8'h01);
		wr(`TCU_ADDR_TCTL, 8'h10);
		rate(`TCU_ADDR_TL0, 120, 10);
		wr(`TCU_ADDR_TCTL, 8'h00);
		rate(`TCU_ADDR_TL0, 120, 0);
		wr(`TCU_ADDR_TL0, 8'hff);
		wr(`TCU_ADDR_TH0, 8'hff);
		wr(`TCU_ADDR_TCTL, 8'h10);
		repeat (14) @(posedge core_clk);
		chk_rd(`TCU_ADDR_TCTL, 8'h30);
		ackp('{tf1: 1'b0, tf0: 1'b1, ie1: 1'b0, ie0: 1'b0});
		chk_rd(`TCU_ADDR_TCTL, 8'h10);
		done("timer0 rate");
		// every mode of timer zero as a counter, random edge counts
		for (int m = 0; m < 4; m++) begin
			seed = lfsr(seed);
			n = 2 + int'(seed % 4);
			h = (m == 2) ? 8'hc3 : 8'hff;
			l = 8'hfe;
			ovf = 1'b0;
			wr(`TCU_ADDR_TCTL, 8'h00);
			wr(`TCU_ADDR_TIMER_MODE_SELECT_REG, 8'h04 | 8'(m));
			wr(`TCU_ADDR_TL0, l);
			wr(`TCU_ADDR_TH0, h);
			wr(`TCU_ADDR_TCTL, 8'h10);
			u_pins.pulse(0, n, 1 + int'(seed[0]));
			for (int i = 0; i < n; i++) begin
				st = t0_step(2'(m), h, l);
				ovf = ovf | st[16];
				{h, l} = st[15:0];
			end
			repeat (3) @(posedge core_clk);
			chk_rd(`TCU_ADDR_TL0, l);
			chk_rd(`TCU_ADDR_TH0, h);
			chk_rd(`TCU_ADDR_TCTL, ovf ? 8'h30 : 8'h10);
		end
		done("timer0 modes");
		// timer one frozen, then running while timer zero is split
		wr(`TCU_ADDR_TIMER_MODE_SELECT_REG, 8'h73);
		wr(`TCU_ADDR_TL1, 8'h55);
		wr(`TCU_ADDR_TCTL, 8'h40);
		u_pins.pulse(1, 3, 1);
		repeat (3) @(posedge core_clk);
		chk_rd(`TCU_ADDR_TL1, 8'h55);
		wr(`TCU_ADDR_TIMER_MODE_SELECT_REG, 8'h63);
		wr(`TCU_ADDR_TL1, 8'hfe);
		wr(`TCU_ADDR_TH1, 8'h80);
		u_pins.pulse(1, 3, 1);
		repeat (3) @(posedge core_clk);
		chk_rd(`TCU_ADDR_TL1, 8'h81);
		wr(`TCU_ADDR_TIMER_MODE_SELECT_REG, 8'h50);
		wr(`TCU_ADDR_TL1, 8'hff);
		wr(`TCU_ADDR_TH1, 8'hff);
		wr(`TCU_ADDR_TCTL, 8'h40);
		n0 = t1_pulses;
		u_pins.pulse(1, 1, 2);
		repeat (3) @(posedge core_clk);
		chk_rd(`TCU_ADDR_TL1, 8'h00);
		chk_rd(`TCU_ADDR_TCTL, 8'hc0);
		`TCU_CHK(t1_pulses, n0 + 1)
		done("timer1");
		// gate held low, external flags in edge and level type
		wr(`TCU_ADDR_TIMER_MODE_SELECT_REG, 8'h8d);
		chk_rd(`TCU_ADDR_TIMER_MODE_SELECT_REG, 8'h0d);
		wr(`TCU_ADDR_TL0, 8'h00);
		wr(`TCU_ADDR_TH0, 8'h00);
		wr(`TCU_ADDR_TCTL, 8'h11);
		u_pins.set_pin(3, 1'b0);
		u_pins.set_pin(4, 1'b0);
		u_pins.pulse(0, 3, 1);
		repeat (3) @(posedge core_clk);
		chk_rd(`TCU_ADDR_TL0, 8'h00);
		chk_rd(`TCU_ADDR_TCTL, 8'h1b);
		u_pins.set_pin(3, 1'b1);
		u_pins.set_pin(4, 1'b1);
		repeat (4) @(posedge core_clk);
		ackp('{tf1: 1'b0, tf0: 1'b0, ie1: 1'b1, ie0: 1'b1});
		chk_rd(`TCU_ADDR_TCTL, 8'h11);
		u_pins.pulse(0, 2, 2);
		repeat (3) @(posedge core_clk);
		chk_rd(`TCU_ADDR_TL0, 8'h02);
		done("gate and irq");
		// third timer: prescale, event with reload, gating, stop
		wr(`TCU_ADDR_T2CTL, 8'h01);
		rate(`TCU_ADDR_TL2, 120, 10);
		wr(`TCU_ADDR_T2CTL, 8'h81);
		rate(`TCU_ADDR_TL2, 120, 5);
		// event mode first, so no prescaled step lands between the byte writes
		wr(`TCU_ADDR_T2CTL, 8'h12);
		wr(`TCU_ADDR_CRCL, 8'h34);
		wr(`TCU_ADDR_CRCH, 8'h12);
		wr(`TCU_ADDR_TL2, 8'hfe);
		wr(`TCU_ADDR_TH2, 8'hff);
		n0 = t2_pulses;
		u_pins.pulse(2, 3, 1);
		repeat (3) @(posedge core_clk);
		chk_rd(`TCU_ADDR_TL2, 8'h35);
		chk_rd(`TCU_ADDR_TH2, 8'h12);
		`TCU_CHK(t2_pulses, n0 + 1)
		wr(`TCU_ADDR_T2CTL, 8'h03);
		u_pins.set_pin(2, 1'b0);
		rate(`TCU_ADDR_TL2, 48, 0);
		u_pins.set_pin(2, 1'b1);
		repeat (3) @(posedge core_clk);
		rate(`TCU_ADDR_TL2, 120, 10);
		wr(`TCU_ADDR_T2CTL, 8'h00);
		rate(`TCU_ADDR_TL2, 48, 0);
		done("third timer");
		// capture snapshot, then reload on the slow trigger
		wr(`TCU_ADDR_T2CTL, 8'h02);
		wr(`TCU_ADDR_TL2, 8'h5a);
		wr(`TCU_ADDR_TH2, 8'h6b);
		wr(`TCU_ADDR_CCEN, 8'h0c);
		wr(`TCU_ADDR_CCL1, 8'haa);
		chk_rd(`TCU_ADDR_CCL1, 8'h5a);
		chk_rd(8'hc3, 8'h6b);
		chk_rd(`TCU_ADDR_TL2, 8'h5a);
		wr(`TCU_ADDR_T2CTL, 8'h18);
		wr(`TCU_ADDR_TL2, 8'h00);
		wr(`TCU_ADDR_TH2, 8'h00);
		repeat (140) @(posedge core_clk);
		chk_rd(`TCU_ADDR_TL2, 8'h34);
		chk_rd(`TCU_ADDR_TH2, 8'h12);
		done("capture and reload");
		wrap_up();
	end

endmodule : tcu_top_tb
